// ---- include/egs_pkg.sv ----
// package of constants for the electronic gear supervisor
package egs_pkg;
	// register byte offsets
	localparam logic [11:0] CTRL_OFFSET   = 12'h000;
	localparam logic [11:0] CFG_OFFSET    = 12'h004;
	localparam logic [11:0] CMD_OFFSET    = 12'h008;
	localparam logic [11:0] STATUS_OFFSET = 12'h00c;
	localparam logic [11:0] ERROR_OFFSET  = 12'h010;
	localparam logic [11:0] LIMIT_OFFSET  = 12'h014;
	localparam logic [11:0] FEED_OFFSET   = 12'h018;
	localparam logic [11:0] POS_OFFSET    = 12'h01c;
	// control bits
	localparam int CTRL_MANUAL     = 0;
	localparam int CTRL_FORCED_END = 1;
	localparam int CTRL_PAUSE      = 2;
	localparam int CTRL_UNLOCK     = 3;
	localparam int CTRL_ERR_RESET  = 4;
	localparam int CTRL_DECEL      = 5;
	localparam int CTRL_SYS_ERR    = 6;
	localparam int CTRL_TASK_ERR   = 7;
	localparam int CTRL_AXIS_ERR   = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// configuration bits
	localparam int CFG_MODE_LSB   = 0;
	localparam int CFG_REPEAT     = 2;
	localparam int CFG_HANDWHEEL  = 3;
	localparam int CFG_HW_X4      = 4;
	localparam int CFG_LIMITS_ON  = 5;
	localparam int CFG_ORIGIN_OK  = 6;
	localparam int CFG_BACKLASH   = 7;
	localparam int CFG_UNIT_LSB   = 8;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [1:0] MODE_STOP  = 2'h0;
	localparam logic [1:0] MODE_PASS  = 2'h1;
	localparam logic [1:0] MODE_INPOS = 2'h2;
	// command codes
	localparam logic [1:0] CMD_START    = 2'h1;
	localparam logic [1:0] CMD_CANCEL   = 2'h2;
	localparam logic [1:0] CMD_CONTINUE = 2'h3;
	// error bits
	localparam int ERR_CW      = 0;
	localparam int ERR_CCW     = 1;
	localparam int ERR_ESTOP   = 2;
	localparam int ERR_ALARM   = 3;
	localparam int ERR_SOFTLIM = 4;
	localparam int ERR_OVERFLOW = 5;
	localparam logic [5:0] ERR_RESET = 6'h00;
	localparam logic [15:0] FEED_RESET = 16'hffff;
	localparam logic [15:0] LIMIT_RESET = 16'h7fff;
	localparam logic [15:0] BACKLASH_PULSES = 16'h0004;
	localparam logic [15:0] SPEED_WINDOW = 16'h0100;
	typedef enum logic [4:0] {
		ST_IDLE    = 5'h01,
		ST_GEAR    = 5'h02,
		ST_PAUSED  = 5'h04,
		ST_DRAIN   = 5'h08,
		ST_HALTED  = 5'h10
	} egs_state_type;
endpackage

// ---- verilog/egs_top.sv ----
// electronic gear supervisor for one operating axis
// Notes on behaviour
// RQ1: stop mode with repeat end never completes; cancel then does nothing.
// RQ2: pass or in-position-off mode: cancel command ends an active gear.
// RQ3: manual mode pauses gear at once; resume only if axis unmoved.
// RQ4: forced block end stops at once; continue flushes queue, restarts block.
// RQ5: pause bit halts at once; resume only if axis unmoved.
// RQ6: servo unlock halts at once; no continuation allowed.
// RQ7: axis operating flag held high while gearing.
// RQ8: positioning completed flag held low while gearing.
// RQ9: error counter reset stops tasks; its release restarts preread.
// RQ10: deceleration stop drains remaining error counter pulses, then stops.
// RQ11: limit inputs raise cw or ccw overtravel error, immediate stop.
// RQ12: emergency stop input raises error, immediate stop.
// RQ13: driver alarm input raises error, immediate stop.
// RQ14: handwheel selectable as input; counting follows its setting.
// RQ15: system error stops gearing at once.
// RQ16: task error stops gearing in this task at once.
// RQ17: axis error stops gearing at once.
// RQ18: minimum unit and pulse rate settings do not affect gearing.
// RQ19: soft limits checked only when configured and origin established.
// RQ20: command speed above max feed rate raises ratio overflow error.
// RQ21: backlash compensation applied on direction changes while gearing.
// RQ22: in-position check on cancel by mode; on stops always.
// RQ23: immediate stop cuts command pulses; PULSE_OUT is low from the next cycle on.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module egs_top (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        INPUT_STEP,
	input  wire logic        INPUT_DIR,
	input  wire logic        HANDWHEEL_A,
	input  wire logic        HANDWHEEL_B,
	input  wire logic        LIMIT_CW,
	input  wire logic        LIMIT_CCW,
	input  wire logic        ESTOP,
	input  wire logic        DRIVER_ALARM,
	input  wire logic        AXIS_MOVED,
	input  wire logic        IN_POSITION,
	output logic             PULSE_OUT,
	output logic             DIR_OUT,
	output logic             AXIS_OPERATING,
	output logic             POS_COMPLETED,
	output logic             PREREAD_RESTART,
	output logic             QUEUE_FLUSH
);
	// ==========================================================
	// registers
	logic [31:0]                  ctrl;
	logic [31:0]                  cfg;
	logic [5:0]                   err;
	logic [15:0]                  feed_max;
	logic [15:0]                  soft_limit;
	logic signed [15:0]           position;
	logic [15:0]                  drain_count;
	logic [15:0]                  speed_count;
	logic [15:0]                  speed_window;
	logic [2:0]                   backlash_left;
	logic                         last_dir;
	logic                         hw_a_prev;
	logic                         err_reset_prev;
	logic                         moved_in_pause;
	logic                         resume_from_block;
	egs_pkg::egs_state_type       state;
	logic                         wr;
	logic                         cmd_wr;
	logic [1:0]                   cmd;
	logic                         stop_now;
	logic                         hard_stop;
	logic                         soft_pause;
	logic                         in_step;
	logic                         in_dir;
	logic                         next_pulse;
	logic                         can_finish;
	logic                         gearing;
	logic [5:0]                   next_err;
	logic [1:0]                   mode;
	logic                         mode_pass;
	logic [15:0]                  window_len;
	logic                         over_limit;
	logic                         over_high;
	logic                         over_low;
	logic                         do_cancel;
	logic                         continue_ok;
	localparam logic [2:0]        BACKLASH_LEN = egs_pkg::BACKLASH_PULSES[2:0];
	// ==========================================================
	// bus decode and mode
	assign window_len = egs_pkg::SPEED_WINDOW;
	assign wr     = PSEL && PENABLE && PWRITE;
	assign cmd_wr = wr && (PADDR == egs_pkg::CMD_OFFSET);
	assign cmd    = PWDATA[1:0];
	assign mode   = cfg[egs_pkg::CFG_MODE_LSB +: 2];
	assign mode_pass = (mode == egs_pkg::MODE_PASS) || (mode == egs_pkg::MODE_INPOS);
	assign gearing = (state == egs_pkg::ST_GEAR);
	// ==========================================================
	// stop conditions
	assign next_err[egs_pkg::ERR_CW]    = err[egs_pkg::ERR_CW] || (gearing && LIMIT_CW);              // RQ11
	assign next_err[egs_pkg::ERR_CCW]   = err[egs_pkg::ERR_CCW] || (gearing && LIMIT_CCW);            // RQ11
	assign next_err[egs_pkg::ERR_ESTOP] = err[egs_pkg::ERR_ESTOP] || (gearing && ESTOP);              // RQ12
	assign next_err[egs_pkg::ERR_ALARM] = err[egs_pkg::ERR_ALARM] || (gearing && DRIVER_ALARM);       // RQ13
	assign over_high  = $signed({position[15], position}) > $signed({1'b0, soft_limit});
	assign over_low   = $signed({position[15], position}) < -$signed({1'b0, soft_limit});
	assign over_limit = over_high || over_low;
	assign next_err[egs_pkg::ERR_SOFTLIM] = err[egs_pkg::ERR_SOFTLIM] || (gearing
		&& cfg[egs_pkg::CFG_LIMITS_ON] && cfg[egs_pkg::CFG_ORIGIN_OK] && over_limit);             // RQ19
	assign next_err[egs_pkg::ERR_OVERFLOW] = err[egs_pkg::ERR_OVERFLOW]
		|| (gearing && speed_count > feed_max);                                                   // RQ20
	assign hard_stop = LIMIT_CW || LIMIT_CCW || ESTOP || DRIVER_ALARM || (|next_err)
		|| ctrl[egs_pkg::CTRL_SYS_ERR] || ctrl[egs_pkg::CTRL_TASK_ERR]
		|| ctrl[egs_pkg::CTRL_AXIS_ERR] || ctrl[egs_pkg::CTRL_UNLOCK]
		|| ctrl[egs_pkg::CTRL_ERR_RESET];                                                        // RQ15 RQ16 RQ17 RQ6 RQ9
	assign soft_pause = ctrl[egs_pkg::CTRL_MANUAL] || ctrl[egs_pkg::CTRL_PAUSE]
		|| ctrl[egs_pkg::CTRL_FORCED_END];                                                       // RQ3 RQ5 RQ4
	assign stop_now = hard_stop || soft_pause;
	// ==========================================================
	// input axis selection, unit and pulse rate unused
	always_comb begin
		if (cfg[egs_pkg::CFG_HANDWHEEL]) begin                                                   // RQ14
			in_step = cfg[egs_pkg::CFG_HW_X4] ? (HANDWHEEL_A != hw_a_prev) : (HANDWHEEL_A && !hw_a_prev);
			in_dir  = HANDWHEEL_B;
		end else begin
			in_step = INPUT_STEP;
			in_dir  = INPUT_DIR;
		end
	end                                                                                          // RQ18
	// ==========================================================
	// handwheel edge history
	always_ff @(posedge CLK) begin
		if (RST) begin
			hw_a_prev <= 1'b0;
		end else begin
			hw_a_prev <= HANDWHEEL_A;
		end
	end
	// ==========================================================
	// pulse generation
	always_comb begin
		next_pulse = 1'b0;
		if (gearing && !stop_now && in_step && backlash_left == 3'h0) begin                      // RQ23
			next_pulse = 1'b1;
		end else if (state == egs_pkg::ST_DRAIN && drain_count != 16'h0000 && !hard_stop) begin // RQ10
			next_pulse = 1'b1;
		end
	end
	always_ff @(posedge CLK) begin
		if (RST) begin
			PULSE_OUT <= 1'b0;
			DIR_OUT   <= 1'b0;
			last_dir  <= 1'b0;
			backlash_left <= 3'h0;
		end else begin
			PULSE_OUT <= next_pulse;
			if (gearing && in_step && in_dir != last_dir && cfg[egs_pkg::CFG_BACKLASH]) begin   // RQ21
				backlash_left <= BACKLASH_LEN;
				last_dir      <= in_dir;
				DIR_OUT       <= in_dir;
			end else if (backlash_left != 3'h0 && gearing) begin
				backlash_left <= backlash_left - 3'h1;
			end else if (gearing && in_step) begin
				last_dir <= in_dir;
				DIR_OUT  <= in_dir;
			end
		end
	end
	always_ff @(posedge CLK) begin
		if (RST) begin
			position <= 16'sh0000;
		end else if (next_pulse) begin
			position <= DIR_OUT ? position - 16'sh0001 : position + 16'sh0001;
		end
	end
	// ==========================================================
	// speed over a fixed window
	always_ff @(posedge CLK) begin
		if (RST) begin
			speed_window <= 16'h0000;
			speed_count  <= 16'h0000;
		end else if (speed_window == window_len - 16'h0001) begin
			speed_window <= 16'h0000;
			speed_count  <= 16'h0000;
		end else begin
			speed_window <= speed_window + 16'h0001;
			if (gearing && in_step) begin
				speed_count <= speed_count + 16'h0001;
			end
		end
	end
	// ==========================================================
	// command decode
	assign can_finish = mode_pass || !cfg[egs_pkg::CFG_REPEAT];                                 // RQ1
	assign do_cancel  = cmd_wr && cmd == egs_pkg::CMD_CANCEL && gearing && can_finish
		&& mode_pass;                                                                            // RQ2
	assign continue_ok = cmd_wr && cmd == egs_pkg::CMD_CONTINUE && !soft_pause && IN_POSITION;  // RQ22
	// ==========================================================
	// state machine
	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= egs_pkg::ST_IDLE;
			moved_in_pause <= 1'b0;
			resume_from_block <= 1'b0;
			drain_count <= 16'h0000;
		end else begin
			unique case (state)
				egs_pkg::ST_IDLE: begin
					if (cmd_wr && cmd == egs_pkg::CMD_START && !stop_now) begin
						state <= egs_pkg::ST_GEAR;
					end
				end
				egs_pkg::ST_GEAR: begin
					if (hard_stop) begin
						state <= egs_pkg::ST_HALTED;
					end else if (soft_pause) begin
						state <= egs_pkg::ST_PAUSED;
						moved_in_pause <= 1'b0;
						resume_from_block <= ctrl[egs_pkg::CTRL_FORCED_END];
					end else if (ctrl[egs_pkg::CTRL_DECEL]) begin
						state <= egs_pkg::ST_DRAIN;
						drain_count <= {13'h0000, backlash_left} + 16'h0001;
					end else if (do_cancel && (IN_POSITION || mode == egs_pkg::MODE_INPOS)) begin // RQ22
						state <= egs_pkg::ST_IDLE;
					end
				end
				egs_pkg::ST_PAUSED: begin
					if (AXIS_MOVED) begin
						moved_in_pause <= 1'b1;
					end
					if (hard_stop) begin
						state <= egs_pkg::ST_HALTED;
					end else if (continue_ok) begin                                               // RQ22
						if (resume_from_block) begin
							state <= egs_pkg::ST_GEAR;                                            // RQ4
						end else if (!moved_in_pause && !AXIS_MOVED) begin
							state <= egs_pkg::ST_GEAR;                                            // RQ3 RQ5
						end else begin
							state <= egs_pkg::ST_HALTED;
						end
					end
				end
				egs_pkg::ST_DRAIN: begin
					if (hard_stop || drain_count == 16'h0000) begin
						state <= egs_pkg::ST_IDLE;
					end else begin
						drain_count <= drain_count - 16'h0001;
					end
				end
				egs_pkg::ST_HALTED: begin
					if (!hard_stop && !soft_pause && cmd_wr && cmd == egs_pkg::CMD_CANCEL && err == 6'h00) begin
						state <= egs_pkg::ST_IDLE;                                                // RQ6
					end
				end
				default: begin
					state <= egs_pkg::ST_IDLE;
				end
			endcase
		end
	end
	// ==========================================================
	// status outputs
	always_ff @(posedge CLK) begin
		if (RST) begin
			AXIS_OPERATING  <= 1'b0;
			POS_COMPLETED   <= 1'b1;
			PREREAD_RESTART <= 1'b0;
			QUEUE_FLUSH     <= 1'b0;
			err_reset_prev  <= 1'b0;
		end else begin
			AXIS_OPERATING  <= (state == egs_pkg::ST_GEAR) || (state == egs_pkg::ST_DRAIN);   // RQ7
			POS_COMPLETED   <= !((state == egs_pkg::ST_GEAR) || (state == egs_pkg::ST_DRAIN)) && IN_POSITION; // RQ8
			err_reset_prev  <= ctrl[egs_pkg::CTRL_ERR_RESET];
			PREREAD_RESTART <= err_reset_prev && !ctrl[egs_pkg::CTRL_ERR_RESET];               // RQ9
			QUEUE_FLUSH     <= state == egs_pkg::ST_PAUSED && resume_from_block && continue_ok; // RQ4
		end
	end
	// ==========================================================
	// apb slave
	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl       <= egs_pkg::CTRL_RESET;
			cfg        <= egs_pkg::CFG_RESET;
			feed_max   <= egs_pkg::FEED_RESET;
			soft_limit <= egs_pkg::LIMIT_RESET;
			err        <= egs_pkg::ERR_RESET;
		end else begin
			if (wr && PADDR == egs_pkg::CTRL_OFFSET) begin
				ctrl <= PWDATA;
			end
			if (wr && PADDR == egs_pkg::CFG_OFFSET) begin
				cfg <= PWDATA;
			end
			if (wr && PADDR == egs_pkg::FEED_OFFSET) begin
				feed_max <= PWDATA[15:0];
			end
			if (wr && PADDR == egs_pkg::LIMIT_OFFSET) begin
				soft_limit <= PWDATA[15:0];
			end
			if (wr && PADDR == egs_pkg::ERROR_OFFSET) begin
				err <= next_err & ~PWDATA[5:0] | (next_err & ~err);
			end else begin
				err <= next_err;
			end
		end
	end
	// ==========================================================
	// apb read path
	always_ff @(posedge CLK) begin
		if (RST) begin
			PRDATA  <= 32'h0000_0000;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= PSEL && !PENABLE;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			if (PSEL && !PENABLE) begin
				unique case (PADDR)
					egs_pkg::CTRL_OFFSET:   PRDATA <= ctrl;
					egs_pkg::CFG_OFFSET:    PRDATA <= cfg;
					egs_pkg::CMD_OFFSET:    PRDATA <= 32'h0000_0000;
					egs_pkg::STATUS_OFFSET: PRDATA <= {27'h0000000, state};
					egs_pkg::ERROR_OFFSET:  PRDATA <= {26'h0000000, err};
					egs_pkg::LIMIT_OFFSET:  PRDATA <= {16'h0000, soft_limit};
					egs_pkg::FEED_OFFSET:   PRDATA <= {16'h0000, feed_max};
					egs_pkg::POS_OFFSET:    PRDATA <= {{16{position[15]}}, position};
					default: begin
						PRDATA  <= 32'h0000_0000;
						PSLVERR <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/egs_props.sv ----
// port assertions for the gear supervisor
`timescale 1ns/1ps
`default_nettype none
module egs_props (
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        LIMIT_CW,
	input wire logic        LIMIT_CCW,
	input wire logic        ESTOP,
	input wire logic        DRIVER_ALARM,
	input wire logic        PULSE_OUT,
	input wire logic        AXIS_OPERATING,
	input wire logic        POS_COMPLETED,
	input wire logic        PREREAD_RESTART,
	input wire logic        QUEUE_FLUSH
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// ==========
	// stopping control write
	logic stop_wr;
	assign stop_wr = PSEL && PENABLE && PWRITE && PADDR == egs_pkg::CTRL_OFFSET && (PWDATA & 32'h1cf) != 32'h0;
	// ==========
	// properties
	a_estop_halt: assert property (ESTOP |=> !PULSE_OUT) else $error("pulse after emergency stop");
	a_alarm_halt: assert property (DRIVER_ALARM |=> !PULSE_OUT) else $error("pulse after alarm");
	a_limit_halt: assert property ((LIMIT_CW || LIMIT_CCW) |=> !PULSE_OUT) else $error("pulse past limit");
	a_ctrl_halt: assert property (stop_wr |=> ##1 (!PULSE_OUT) [*4]) else $error("pulse after stop bit");
	a_pulse_busy: assert property (PULSE_OUT |-> AXIS_OPERATING && !POS_COMPLETED)
		else $error("flags wrong while pulsing");
	a_flush_pulse: assert property (QUEUE_FLUSH |=> !QUEUE_FLUSH) else $error("flush too long");
	a_preread_once: assert property ($rose(PREREAD_RESTART) |=> !PREREAD_RESTART) else $error("restart long");
	a_ready_answer: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY) else $error("ready timing");
	a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
endmodule
bind egs_top egs_props props_u (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR,
	.LIMIT_CW, .LIMIT_CCW, .ESTOP, .DRIVER_ALARM, .PULSE_OUT, .AXIS_OPERATING, .POS_COMPLETED,
	.PREREAD_RESTART, .QUEUE_FLUSH);
`default_nettype wire

// ---- tb/egs_servo_model.sv ----
// servo, switches and input axis model
`timescale 1ns/1ps
`default_nettype none
module egs_servo_model #(
	parameter int SETTLE = 6
) (
	input wire logic       CLK,
	input wire logic       RST,
	input wire logic       PULSE_OUT,
	input wire logic       step_en,
	input wire logic       hw_en,
	input wire logic       moved,
	input wire logic [3:0] fault,
	output logic           INPUT_STEP,
	output logic           INPUT_DIR,
	output logic           HANDWHEEL_A,
	output logic           HANDWHEEL_B,
	output logic           LIMIT_CW,
	output logic           LIMIT_CCW,
	output logic           ESTOP,
	output logic           DRIVER_ALARM,
	output logic           AXIS_MOVED,
	output logic           IN_POSITION
);
	logic [7:0] ph;
	int         quiet;
	// ==========
	// steps, quadrature, switches, settling
	always_ff @(posedge CLK) begin
		ph <= RST ? 8'h00 : ph + 8'h01;
		INPUT_STEP <= step_en && ph[1:0] == 2'h0;
		INPUT_DIR <= 1'h1;
		HANDWHEEL_A <= hw_en && ph[3];
		HANDWHEEL_B <= hw_en && (ph[3] ^ ph[2]);
		{DRIVER_ALARM, ESTOP, LIMIT_CCW, LIMIT_CW} <= fault;
		AXIS_MOVED <= moved;
		quiet <= (RST || PULSE_OUT) ? 0 : quiet + 1;
		IN_POSITION <= quiet >= SETTLE;
	end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking testbench for the gear supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {logic [31:0] m; logic [31:0] v; logic e;} egs_note_type;
	logic CLK, RST, PSEL, PENABLE, PWRITE, step_en, hw_en, moved;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, c0, c1;
	logic [3:0] fault;
	wire [31:0] PRDATA;
	wire PREADY, PSLVERR, INPUT_STEP, INPUT_DIR, HANDWHEEL_A, HANDWHEEL_B, LIMIT_CW, LIMIT_CCW;
	wire ESTOP, DRIVER_ALARM, AXIS_MOVED, IN_POSITION, PULSE_OUT, DIR_OUT;
	wire AXIS_OPERATING, POS_COMPLETED, PREREAD_RESTART, QUEUE_FLUSH;
	int err_total, total_checks, npul, nfl, npr;
	egs_note_type q[$];
	egs_note_type nt;
	egs_top dut_u (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
		.INPUT_STEP, .INPUT_DIR, .HANDWHEEL_A, .HANDWHEEL_B, .LIMIT_CW, .LIMIT_CCW, .ESTOP,
		.DRIVER_ALARM, .AXIS_MOVED, .IN_POSITION, .PULSE_OUT, .DIR_OUT, .AXIS_OPERATING,
		.POS_COMPLETED, .PREREAD_RESTART, .QUEUE_FLUSH);
	egs_servo_model srv_u (.CLK, .RST, .PULSE_OUT, .step_en, .hw_en, .moved, .fault, .INPUT_STEP,
		.INPUT_DIR, .HANDWHEEL_A, .HANDWHEEL_B, .LIMIT_CW, .LIMIT_CCW, .ESTOP, .DRIVER_ALARM,
		.AXIS_MOVED, .IN_POSITION);
	initial begin
		CLK = 1'h0;
		forever #12.5 CLK = ~CLK;
	end
	// ==========
	// output watchers
	always @(negedge CLK) begin
		npul += (PULSE_OUT === 1'h1);
		nfl += (QUEUE_FLUSH === 1'h1);
		npr += (PREREAD_RESTART === 1'h1);
	end
	always @(posedge CLK) begin
		if (PSEL && PENABLE && PREADY === 1'h1 && !PWRITE) begin
			nt = q.pop_front();
			chk("read data", nt.v, PRDATA & nt.m);
			chk("read error", {31'h0, nt.e}, {31'h0, PSLVERR});
		end
	end
	// ==========
	// tasks
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s exp %h got %h", s, e, g);
		end
	endtask
	task cyc(int n);
		repeat (n) @(posedge CLK);
	endtask
	task xfer(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		PENABLE <= 1'h0;
		@(posedge CLK);
		PENABLE <= 1'h1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'h1 && n < 50);
		if (n == 50) chk("pready", 32'h1, 32'h0);
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge CLK);
	endtask
	task rd(logic [11:0] a, logic [31:0] m, logic [31:0] v, logic e);
		q.push_back({m, v, e});
		xfer(1'h0, a, 32'h0);
	endtask
	task st(logic [31:0] m, logic [31:0] v);
		rd(egs_pkg::STATUS_OFFSET, m, v, 1'h0);
	endtask
	task er(logic [31:0] m, logic [31:0] v);
		rd(egs_pkg::ERROR_OFFSET, m, v, 1'h0);
	endtask
	task ctl(logic [31:0] d);
		xfer(1'h1, egs_pkg::CTRL_OFFSET, d);
	endtask
	task cmd(logic [1:0] c);
		xfer(1'h1, egs_pkg::CMD_OFFSET, {30'h0, c});
	endtask
	task gear(logic [31:0] cfg);
		xfer(1'h1, egs_pkg::CFG_OFFSET, cfg);
		cmd(egs_pkg::CMD_START);
	endtask
	task rst();
		RST <= 1'h1;
		step_en <= 1'h0;
		hw_en <= 1'h0;
		moved <= 1'h0;
		fault <= 4'h0;
		cyc(3);
		RST <= 1'h0;
		cyc(1);
	endtask
	task give_verdict();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ==========
	// tests
	initial begin
		{RST, PSEL, PENABLE, PWRITE, step_en, hw_en, moved} = 7'h40;
		{PADDR, PWDATA, fault} = 48'h0;
		c0 = $urandom(32'h1bb3c5d2);
		rst();
		rd(egs_pkg::CTRL_OFFSET, '1, egs_pkg::CTRL_RESET, 1'h0);
		rd(egs_pkg::CFG_OFFSET, '1, egs_pkg::CFG_RESET, 1'h0);
		rd(egs_pkg::LIMIT_OFFSET, 32'hffff, egs_pkg::LIMIT_RESET, 1'h0);
		rd(egs_pkg::FEED_OFFSET, 32'hffff, egs_pkg::FEED_RESET, 1'h0);
		er(32'h3f, egs_pkg::ERR_RESET);
		st(32'h1f, egs_pkg::ST_IDLE);
		rd(12'h020, '1, 32'h0, 1'h1);
		$display("test reset done");
		for (int m = 1; m < 3; m++) begin
			rst();
			gear(m);
			cyc(20);
			@(negedge CLK);
			chk("operating", 32'h1, AXIS_OPERATING);
			chk("completed", 32'h0, POS_COMPLETED);
			@(posedge CLK);
			st(32'h1f, egs_pkg::ST_GEAR);
			cmd(egs_pkg::CMD_CANCEL);
			cyc(4);
			st(32'h2, 32'h0);
		end
		rst();
		gear(32'h4);
		cmd(egs_pkg::CMD_CANCEL);
		cyc(4);
		st(32'h1f, egs_pkg::ST_GEAR);
		$display("test modes done");
		for (int b = 0; b < 9; b++) begin
			rst();
			gear(32'h1);
			step_en <= 1'h1;
			cyc(8);
			ctl(32'h1 << b);
			if (b == 0 || b == 2) st(32'h1f, egs_pkg::ST_PAUSED);
			else st(32'h2, 32'h0);
			cyc(b == 5 ? 400 : 2);
			c0 = npul;
			cyc(20);
			chk("halted pulses", c0, npul);
			c0 = npr;
			c1 = nfl;
			ctl(32'h0);
			cyc(3);
			if (b == 4) chk("preread restart", c0 + 1, npr);
			if (b < 4) begin
				cmd(egs_pkg::CMD_CONTINUE);
				cyc(3);
				if (b == 3) st(32'h2, 32'h0);
				else st(32'h1f, egs_pkg::ST_GEAR);
				if (b == 1) chk("queue flush", c1 + 1, nfl);
			end
		end
		for (int b = 0; b < 3; b += 2) begin
			rst();
			gear(32'h1);
			ctl(32'h1 << b);
			moved <= 1'h1;
			cyc(2);
			moved <= 1'h0;
			ctl(32'h0);
			cmd(egs_pkg::CMD_CONTINUE);
			cyc(3);
			st(32'h2, 32'h0);
		end
		$display("test control bits done");
		for (int i = 0; i < 4; i++) begin
			rst();
			gear(32'h1);
			step_en <= 1'h1;
			cyc(8);
			fault <= 4'h1 << i;
			cyc(4);
			er(32'h1 << i, 32'h1 << i);
			st(32'h2, 32'h0);
			fault <= 4'h0;
			cyc(2);
			xfer(1'h1, egs_pkg::ERROR_OFFSET, 32'h1 << i);
			er(32'h3f, 32'h0);
		end
		rst();
		xfer(1'h1, egs_pkg::FEED_OFFSET, 32'h1);
		gear(32'h1);
		step_en <= 1'h1;
		cyc(600);
		er(32'h20, 32'h20);
		for (int o = 0; o < 2; o++) begin
			rst();
			xfer(1'h1, egs_pkg::LIMIT_OFFSET, 32'h2);
			gear(32'h21 | o << 6);
			step_en <= 1'h1;
			cyc(100);
			er(32'h10, o << 4);
		end
		$display("test errors done");
		for (int h = 0; h < 2; h++) begin
			rst();
			hw_en <= 1'h1;
			c0 = npul;
			gear(32'h9 | h << 4);
			cyc(200);
			if (h == 0) chk("handwheel pulses", 32'h1, npul > c0);
			else chk("handwheel both edges", 32'h1, npul - c0 > c1);
			c1 = npul - c0;
		end
		for (int u = 0; u < 3; u++) begin
			rst();
			gear(32'h1 | (u == 1 ? $urandom & 32'hff00 : 32'h0) | (u == 2 ? 32'h80 : 32'h0));
			c0 = npul;
			step_en <= 1'h1;
			cyc(64);
			step_en <= 1'h0;
			cyc(20);
			chk("direction", 32'h1, DIR_OUT);
			if (u == 0) c1 = npul - c0;
			else if (u == 1) chk("unit independent", c1, npul - c0);
			else chk("backlash pulses", 32'h1, npul - c0 != c1);
		end
		$display("test inputs done");
		give_verdict();
	end
	initial begin
		#2000000;
		err_total++;
		give_verdict();
	end
endmodule
`default_nettype wire
